// ===== design/t2c_pkg.sv
// Constants, register layout and field types for the timer 2 control block
package t2c_pkg;
   // Register addresses on the special function port
   localparam logic [7:0] ADDR_CONTROL = 8'hC8;
   localparam logic [7:0] ADDR_MODE = 8'hC9;
   localparam logic [7:0] ADDR_CAP_LOW = 8'hCA;
   localparam logic [7:0] ADDR_CAP_HIGH = 8'hCB;
   localparam logic [7:0] ADDR_CNT_LOW = 8'hCC;
   localparam logic [7:0] ADDR_CNT_HIGH = 8'hCD;
   // Mode register field positions
   localparam int MODE_DOWN_BIT = 0;
   localparam int MODE_ONE_BIT = 2;
   localparam int MODE_AUTO_CLEAR_BIT = 3;
   // Reset values and the counter top value
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_TOP = 16'hFFFF;
   localparam logic [7:0] READ_IDLE = 8'h00;
   // Timer prescale in clocks per tick for each speed select value
   localparam logic [3:0] DIV_SLOW = 4'hC;
   localparam logic [3:0] DIV_FAST = 4'h4;
   localparam logic [3:0] DIV_ONE = 4'h1;
   // Serial modes with a variable time-base have mode bit 0 set
   localparam int SERIAL_VAR_BIT = 0;
   // Number of synchronised pins: trigger and count input
   localparam int PIN_COUNT = 2;
   localparam int PIN_TRIGGER = 0;
   localparam int PIN_COUNT_IN = 1;

   // Control register, bit 7 down to bit 0
   typedef struct packed {
      logic overflow_flag;
      logic external_flag;
      logic rx_baud_source_select;
      logic tx_baud_source_select;
      logic external_trigger_enable;
      logic run_control;
      logic counter_timer_select;
      logic capture_reload_select;
   } t2c_control_type;

   // Register port request from the core
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } t2c_req_type;
endpackage

// ===== design/t2c_timer2.sv
// Timer 2 control, capture, reload and baud time-base logic
`timescale 1ns/100ps
`default_nettype none
module t2c_timer2 (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire t2c_pkg::t2c_req_type req_i,
   output logic [7:0] rdata_o,
   input wire logic timer_speed_select_i,
   input wire logic [1:0] serial_mode_i,
   input wire logic timer1_overflow_i,
   input wire logic external_trigger_pin_i,
   input wire logic count_input_pin_i,
   output logic overflow_flag_o,
   output logic external_flag_o,
   output logic timer_irq_o,
   output logic rx_baud_tick_o,
   output logic tx_baud_tick_o
);
   import t2c_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and falling edge detect
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] sync_a;
   logic [PIN_COUNT-1:0] sync_b;
   logic [PIN_COUNT-1:0] sync_c;
   logic [PIN_COUNT-1:0] pin_level;
   logic [PIN_COUNT-1:0] pin_fall;

   assign pin_raw = {count_input_pin_i, external_trigger_pin_i};

   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
         // Pins idle high, so reset to one to avoid a false edge
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               sync_a[gi] <= 1'b1;
               sync_b[gi] <= 1'b1;
               sync_c[gi] <= 1'b1;
               pin_level[gi] <= 1'b1;
            end else begin
               sync_a[gi] <= pin_raw[gi];
               sync_b[gi] <= sync_a[gi];
               sync_c[gi] <= sync_b[gi];
               if (sync_b[gi] == sync_c[gi]) begin
                  pin_level[gi] <= sync_c[gi];
               end
            end
         end
         // Edge counts once the two late stages agree low
         assign pin_fall[gi] = pin_level[gi] & ~sync_b[gi] & ~sync_c[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   t2c_control_type ctrl;
   logic down_count_enable;
   logic capture_auto_clear;
   logic [15:0] cnt;
   logic [15:0] cap;
   logic [3:0] pre_cnt;
   logic half_q;

   // Write decode
   logic ctrl_wr;
   logic mode_wr;
   logic cap_lo_wr;
   logic cap_hi_wr;
   logic cnt_lo_wr;
   logic cnt_hi_wr;
   assign ctrl_wr = req_i.wr && (req_i.addr == ADDR_CONTROL);
   assign mode_wr = req_i.wr && (req_i.addr == ADDR_MODE);
   assign cap_lo_wr = req_i.wr && (req_i.addr == ADDR_CAP_LOW);
   assign cap_hi_wr = req_i.wr && (req_i.addr == ADDR_CAP_HIGH);
   assign cnt_lo_wr = req_i.wr && (req_i.addr == ADDR_CNT_LOW);
   assign cnt_hi_wr = req_i.wr && (req_i.addr == ADDR_CNT_HIGH);

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode
   logic baud_mode;
   logic down_mode;
   logic count_down;
   assign baud_mode = ctrl.rx_baud_source_select | ctrl.tx_baud_source_select;
   // Direction only matters in plain auto-reload mode
   assign down_mode = down_count_enable & ~ctrl.capture_reload_select & ~baud_mode;
   assign count_down = down_mode & ~pin_level[PIN_TRIGGER];

   // Prescaler for timer mode; speed select picks the divisor
   logic [3:0] pre_limit;
   logic pre_pulse;
   assign pre_limit = (timer_speed_select_i ? DIV_FAST : DIV_SLOW) - DIV_ONE;
   assign pre_pulse = (pre_cnt == pre_limit);

   // One tick source per mode; baud mode ignores the select bit
   logic tmr_tick;
   logic tick_src;
   assign tick_src = baud_mode ? half_q :
                     (ctrl.counter_timer_select ? pin_fall[PIN_COUNT_IN] : pre_pulse);
   assign tmr_tick = ctrl.run_control & tick_src;

   // Overflow up at the top, and down at the capture value
   logic up_ovf;
   logic dn_ovf;
   logic ovf;
   assign up_ovf = tmr_tick & ~count_down & (cnt == COUNT_TOP);
   assign dn_ovf = tmr_tick & count_down & (cnt == cap);
   assign ovf = up_ovf | dn_ovf;

   // Trigger edge only acts outside baud and down-count modes
   logic trig_take;
   logic do_capture;
   logic do_reload;
   assign trig_take = pin_fall[PIN_TRIGGER] & ctrl.external_trigger_enable
                      & ~baud_mode & ~down_mode;
   assign do_capture = trig_take & ctrl.capture_reload_select;
   assign do_reload = (trig_take & ~ctrl.capture_reload_select)
                      | (up_ovf & (baud_mode | ~ctrl.capture_reload_select));

   ////////////////////////////////////////////////////////////////////////////
   // Next counter and capture values
   logic [15:0] step_cnt;
   logic [15:0] hw_cnt;
   logic [15:0] next_cnt;
   logic [15:0] next_cap;
   assign step_cnt = count_down ? (cnt - 16'h0001) : (cnt + 16'h0001);
   // Auto-clear wins, then reload, then the down wrap, then a plain step
   assign hw_cnt = (do_capture & capture_auto_clear) ? COUNT_RESET :
                   do_reload ? cap :
                   dn_ovf ? COUNT_TOP :
                   tmr_tick ? step_cnt : cnt;
   // Software byte writes override the hardware value
   assign next_cnt = {cnt_hi_wr ? req_i.wdata : hw_cnt[15:8],
                      cnt_lo_wr ? req_i.wdata : hw_cnt[7:0]};
   // Capture beats a software write in the same cycle, so no event is lost
   assign next_cap = do_capture ? cnt :
                     {cap_hi_wr ? req_i.wdata : cap[15:8],
                      cap_lo_wr ? req_i.wdata : cap[7:0]};

   ////////////////////////////////////////////////////////////////////////////
   // Next control value; hardware set wins over a software clear
   t2c_control_type wr_ctrl;
   t2c_control_type next_ctrl;
   logic ovf_set;
   logic ext_toggle;
   assign wr_ctrl = ctrl_wr ? t2c_control_type'(req_i.wdata) : ctrl;
   assign ovf_set = ovf & ~baud_mode;
   // In down-count mode each overflow flips the external flag
   assign ext_toggle = ovf & down_mode;
   always_comb begin
      next_ctrl = wr_ctrl;
      next_ctrl.overflow_flag = wr_ctrl.overflow_flag | ovf_set;
      next_ctrl.external_flag = (wr_ctrl.external_flag ^ ext_toggle) | trig_take;
   end

   // Time-base choice for serial modes 1 and 3 only
   logic var_mode;
   logic timer2_baud_ovf;
   logic next_rx_tick;
   logic next_tx_tick;
   assign var_mode = serial_mode_i[SERIAL_VAR_BIT];
   assign timer2_baud_ovf = ovf & baud_mode;
   assign next_rx_tick = var_mode & (ctrl.rx_baud_source_select ? timer2_baud_ovf
                                                              : timer1_overflow_i);
   assign next_tx_tick = var_mode & (ctrl.tx_baud_source_select ? timer2_baud_ovf
                                                              : timer1_overflow_i);

   // Read selection; unmapped addresses read zero
   logic [7:0] mode_rd;
   logic [7:0] rd_mux;
   always_comb begin
      mode_rd = READ_IDLE;
      mode_rd[MODE_DOWN_BIT] = down_count_enable;
      mode_rd[MODE_ONE_BIT] = 1'b1;
      mode_rd[MODE_AUTO_CLEAR_BIT] = capture_auto_clear;
   end
   assign rd_mux = (req_i.addr == ADDR_CONTROL) ? ctrl :
                   (req_i.addr == ADDR_MODE) ? mode_rd :
                   (req_i.addr == ADDR_CAP_LOW) ? cap[7:0] :
                   (req_i.addr == ADDR_CAP_HIGH) ? cap[15:8] :
                   (req_i.addr == ADDR_CNT_LOW) ? cnt[7:0] :
                   (req_i.addr == ADDR_CNT_HIGH) ? cnt[15:8] : READ_IDLE;

   ////////////////////////////////////////////////////////////////////////////
   // Timer state
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl <= t2c_control_type'(CONTROL_RESET);
         cnt <= COUNT_RESET;
         cap <= COUNT_RESET;
      end else begin
         ctrl <= next_ctrl;
         cnt <= next_cnt;
         cap <= next_cap;
      end
   end

   // Mode bits written by software only
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         down_count_enable <= 1'b0;
         capture_auto_clear <= 1'b0;
      end else if (mode_wr) begin
         down_count_enable <= req_i.wdata[MODE_DOWN_BIT];
         capture_auto_clear <= req_i.wdata[MODE_AUTO_CLEAR_BIT];
      end
   end

   // Dividers run freely so the rate does not depend on run control
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_cnt <= 4'h0;
         half_q <= 1'b0;
      end else begin
         pre_cnt <= pre_pulse ? 4'h0 : (pre_cnt + 4'h1);
         half_q <= ~half_q;
      end
   end

   // Registered outputs and one-cycle-late read data
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= READ_IDLE;
         timer_irq_o <= 1'b0;
         rx_baud_tick_o <= 1'b0;
         tx_baud_tick_o <= 1'b0;
      end else begin
         rdata_o <= req_i.rd ? rd_mux : READ_IDLE;
         // Enable gating is done by the interrupt controller
         timer_irq_o <= ctrl.overflow_flag | ctrl.external_flag;
         rx_baud_tick_o <= next_rx_tick;
         tx_baud_tick_o <= next_tx_tick;
      end
   end

   assign overflow_flag_o = ctrl.overflow_flag;
   assign external_flag_o = ctrl.external_flag;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   logic cnt_sw_wr;
   assign cnt_sw_wr = cnt_lo_wr | cnt_hi_wr;

   sequence s_baud_tick;
      baud_mode && ctrl.run_control && tmr_tick;
   endsequence

   sequence s_no_tick_next;
      !tmr_tick;
   endsequence

   a_overflow_sets_flag: assert property (
      up_ovf && !baud_mode |=> overflow_flag_o)
      else $error("Up overflow did not set overflow flag");

   a_down_match_flag: assert property (
      tmr_tick && count_down && cnt == cap && !baud_mode |=> overflow_flag_o)
      else $error("Down count match did not set overflow flag");

   a_baud_no_flag: assert property (
      !overflow_flag_o && baud_mode && !ctrl_wr |=> !overflow_flag_o)
      else $error("Overflow flag set while in baud mode");

   a_flag_no_hw_clear: assert property (
      overflow_flag_o && !ctrl_wr |=> overflow_flag_o)
      else $error("Hardware cleared overflow flag");

   a_trigger_sets_ext: assert property (
      trig_take |=> external_flag_o)
      else $error("Trigger edge did not set external flag");

   a_irq_follows_flags: assert property (
      (overflow_flag_o || external_flag_o) |=> timer_irq_o)
      else $error("Interrupt not raised for set flag");

   a_stop_holds_count: assert property (
      !ctrl.run_control && !cnt_sw_wr && !trig_take |=> cnt == $past(cnt))
      else $error("Counter moved while stopped");

   a_baud_half_rate: assert property (
      s_baud_tick ##1 baud_mode |-> s_no_tick_next)
      else $error("Baud mode ticked on two consecutive clocks");

   a_capture_copies: assert property (
      do_capture |=> cap == $past(cnt))
      else $error("Capture did not copy the counter");

   a_reload_on_ovf: assert property (
      up_ovf && baud_mode && !cnt_sw_wr |=> cnt == $past(cap))
      else $error("Baud mode overflow did not reload");

   a_auto_clear: assert property (
      do_capture && capture_auto_clear && !cnt_sw_wr |=> cnt == COUNT_RESET)
      else $error("Capture auto-clear did not zero the counter");

   a_rx_source: assert property (
      var_mode && !ctrl.rx_baud_source_select |=> rx_baud_tick_o == $past(timer1_overflow_i))
      else $error("Receive time-base not taken from timer 1");

   a_trigger_ignored: assert property (
      !ctrl.external_trigger_enable && !ctrl_wr |=> external_flag_o == $past(external_flag_o)
                                        || $past(ext_toggle))
      else $error("Trigger pin acted while disabled");

   a_tx_source: assert property (
      var_mode && !ctrl.tx_baud_source_select |=> tx_baud_tick_o == $past(timer1_overflow_i))
      else $error("Transmit time-base not taken from timer 1");

   a_rx_timer2: assert property (
      var_mode && ctrl.rx_baud_source_select |=> rx_baud_tick_o == $past(up_ovf))
      else $error("Receive time-base not taken from timer 2");

   a_baud_no_ext: assert property (
      baud_mode && !external_flag_o && !ctrl_wr |=> !external_flag_o)
      else $error("Trigger pin acted during baud generation");

   a_reload_mode_ovf: assert property (
      up_ovf && !ctrl.capture_reload_select && !cnt_sw_wr |=> cnt == $past(cap))
      else $error("Reload mode overflow did not reload");

   a_trigger_reload: assert property (
      trig_take && !ctrl.capture_reload_select && !cnt_sw_wr |=> cnt == $past(cap))
      else $error("Trigger edge did not reload the counter");

   a_down_wrap: assert property (
      dn_ovf && !cnt_sw_wr |=> cnt == COUNT_TOP)
      else $error("Down count match did not load the top value");

   a_count_needs_edge: assert property (
      ctrl.counter_timer_select && !baud_mode && !pin_fall[PIN_COUNT_IN] && !trig_take
      && !cnt_sw_wr |=> cnt == $past(cnt))
      else $error("Counter moved without a count pin edge");

   a_irq_clear: assert property (
      !overflow_flag_o && !external_flag_o |=> !timer_irq_o)
      else $error("Interrupt raised with both flags clear");

   a_sw_sets_flag: assert property (
      ctrl_wr && wr_ctrl.overflow_flag |=> overflow_flag_o)
      else $error("Software write did not set overflow flag");

   a_edge_one_cycle: assert property (
      pin_fall[PIN_TRIGGER] |=> !pin_fall[PIN_TRIGGER])
      else $error("Trigger edge pulse lasted more than one clock");

endmodule
`default_nettype wire

// ===== sim/t2c_pin_model.sv
// Far-side model of the trigger pin, count pin and timer 1 overflow source
`timescale 1ns/100ps
`default_nettype none
module t2c_pin_model (
   input wire logic clk_i,
   output logic trigger_o,
   output logic count_o,
   output logic t1_ovf_o
);
   // Pins idle high so reset never shows a false edge
   initial begin
      trigger_o = 1'b1;
      count_o = 1'b1;
      t1_ovf_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Each level held four clocks, longer than the sampler needs
   task automatic set_trigger(input logic lvl);
      @(posedge clk_i);
      trigger_o <= lvl;
      repeat (4) @(posedge clk_i);
   endtask

   task automatic trigger_fall();
      set_trigger(1'b0);
      set_trigger(1'b1);
   endtask

   task automatic count_fall();
      @(posedge clk_i);
      count_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      count_o <= 1'b1;
      repeat (4) @(posedge clk_i);
   endtask

   // Timer 1 overflow, one cycle wide
   task automatic t1_pulse();
      @(posedge clk_i);
      t1_ovf_o <= 1'b1;
      @(posedge clk_i);
      t1_ovf_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== sim/tb_t2c_timer2.sv
// Self-checking bench for the timer 2 control block
`timescale 1ns/100ps
`default_nettype none
module tb_t2c_timer2;
   import t2c_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   t2c_req_type req = '0;
   logic speed = 1'b0;
   logic [1:0] smode = 2'b00;
   wire logic trig;
   wire logic cnt;
   wire logic t1ovf;
   logic [7:0] rdata;
   logic ovf_f, ext_f, irq, rx_t, tx_t;
   logic rd_pend = 1'b0;
   logic [7:0] exp_q[$];
   int err_total = 0;
   int check_count = 0;
   int n;
   logic [15:0] v;

   always #50 clk_i = ~clk_i;

   t2c_timer2 u_t2c_timer2 (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata),
      .timer_speed_select_i(speed), .serial_mode_i(smode), .timer1_overflow_i(t1ovf),
      .external_trigger_pin_i(trig), .count_input_pin_i(cnt), .overflow_flag_o(ovf_f),
      .external_flag_o(ext_f), .timer_irq_o(irq), .rx_baud_tick_o(rx_t),
      .tx_baud_tick_o(tx_t));

   t2c_pin_model u_t2c_pin_model (.clk_i(clk_i), .trigger_o(trig), .count_o(cnt),
      .t1_ovf_o(t1ovf));

   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string name, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", name, e, g);
         err_total++;
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // One-cycle strobes; an edge always passes before the next request
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      exp_q.push_back(e);
      @(posedge clk_i);
      req.rd <= 1'b0;
   endtask

   // Bounded wait for a transmit tick, seen at a falling edge
   task automatic wait_tx();
      n = 0;
      @(negedge clk_i);
      while (tx_t !== 1'b1 && n < 50) begin
         @(negedge clk_i);
         n++;
      end
      if (tx_t !== 1'b1) begin
         err_total++;
         finish_test();
      end
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge clk_i) rd_pend <= req.rd;
   always @(negedge clk_i) begin
      if (rd_pend && exp_q.size() > 0) begin
         cmp("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h9FD6CE20));
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      // Reset values; unmapped address reads idle
      rd(ADDR_CONTROL, CONTROL_RESET);
      rd(ADDR_MODE, 8'h04);
      for (int a = 8'hCA; a <= 8'hCD; a++) rd(a[7:0], 8'h00);
      rd(8'hC5, READ_IDLE);
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         wr(ADDR_CAP_LOW, v[7:0]);
         wr(ADDR_CAP_HIGH, v[15:8]);
         rd(ADDR_CAP_LOW, v[7:0]);
         rd(ADDR_CAP_HIGH, v[15:8]);
      end
      // Software sets and clears flags; interrupt a cycle later
      wr(ADDR_CONTROL, 8'hC0);
      @(posedge clk_i);
      @(negedge clk_i);
      cmp("flags_set", 16'h0007, {13'h0, ovf_f, ext_f, irq});
      wr(ADDR_CONTROL, 8'h00);
      @(posedge clk_i);
      @(negedge clk_i);
      cmp("flags_clr", 16'h0000, {13'h0, ovf_f, ext_f, irq});
      // Counter mode: overflow from FFFF reloads the capture pair
      wr(ADDR_CAP_LOW, 8'h34);
      wr(ADDR_CAP_HIGH, 8'h12);
      wr(ADDR_CNT_LOW, 8'hFF);
      wr(ADDR_CNT_HIGH, 8'hFF);
      wr(ADDR_CONTROL, 8'h06);
      u_t2c_pin_model.count_fall();
      rd(ADDR_CNT_LOW, 8'h34);
      rd(ADDR_CNT_HIGH, 8'h12);
      rd(ADDR_CONTROL, 8'h86);
      u_t2c_pin_model.count_fall();
      rd(ADDR_CNT_LOW, 8'h35);
      wr(ADDR_CONTROL, 8'h02);
      u_t2c_pin_model.count_fall();
      rd(ADDR_CNT_LOW, 8'h35);
      // Trigger edge acts only with the trigger enable set
      wr(ADDR_CNT_LOW, 8'h55);
      wr(ADDR_CNT_HIGH, 8'h55);
      u_t2c_pin_model.trigger_fall();
      rd(ADDR_CNT_LOW, 8'h55);
      rd(ADDR_CONTROL, 8'h02);
      wr(ADDR_CONTROL, 8'h0E);
      u_t2c_pin_model.trigger_fall();
      rd(ADDR_CNT_LOW, 8'h34);
      rd(ADDR_CONTROL, 8'h4E);
      cmp("irq_trig", 16'h0001, {15'h0, irq});
      wr(ADDR_CONTROL, 8'h0E);
      rd(ADDR_CONTROL, 8'h0E);
      // Capture, then capture with auto-clear of the counter
      wr(ADDR_CNT_LOW, 8'hCD);
      wr(ADDR_CNT_HIGH, 8'hAB);
      wr(ADDR_CONTROL, 8'h0F);
      u_t2c_pin_model.trigger_fall();
      rd(ADDR_CAP_LOW, 8'hCD);
      rd(ADDR_CAP_HIGH, 8'hAB);
      rd(ADDR_CNT_LOW, 8'hCD);
      rd(ADDR_CONTROL, 8'h4F);
      wr(ADDR_MODE, 8'h08);
      rd(ADDR_MODE, 8'h0C);
      u_t2c_pin_model.trigger_fall();
      rd(ADDR_CAP_HIGH, 8'hAB);
      rd(ADDR_CNT_HIGH, 8'h00);
      // Down count: pin low, match with the capture pair loads FFFF
      wr(ADDR_MODE, 8'h01);
      wr(ADDR_CAP_LOW, 8'h10);
      wr(ADDR_CAP_HIGH, 8'h00);
      wr(ADDR_CNT_LOW, 8'h10);
      wr(ADDR_CNT_HIGH, 8'h00);
      wr(ADDR_CONTROL, 8'h06);
      u_t2c_pin_model.set_trigger(1'b0);
      u_t2c_pin_model.count_fall();
      rd(ADDR_CNT_HIGH, 8'hFF);
      rd(ADDR_CONTROL, 8'hC6);
      u_t2c_pin_model.set_trigger(1'b1);
      // Baud mode: reload FFFE on each overflow, a step per two clocks
      wr(ADDR_MODE, 8'h00);
      wr(ADDR_CAP_LOW, 8'hFE);
      wr(ADDR_CAP_HIGH, 8'hFF);
      smode <= 2'b01;
      wr(ADDR_CONTROL, 8'h3C);
      wait_tx();
      cmp("rx_tick", 16'h0001, {15'h0, rx_t});
      wait_tx();
      cmp("baud_gap", 16'h0004, n[15:0] + 16'h0001);
      // Trigger enable set, but baud generation must refuse the edge
      u_t2c_pin_model.trigger_fall();
      rd(ADDR_CONTROL, 8'h3C);
      smode <= 2'b00;
      @(posedge clk_i);
      n = 0;
      repeat (20) begin
         @(negedge clk_i);
         n += int'(tx_t | rx_t);
      end
      cmp("ticks_off", 16'h0000, n[15:0]);
      // Timer 1 feeds transmit only; receive waits on timer 2
      wr(ADDR_CONTROL, 8'h20);
      smode <= 2'b11;
      u_t2c_pin_model.t1_pulse();
      @(negedge clk_i);
      cmp("t1_ticks", 16'h0002, {14'h0, tx_t, rx_t});
      // Timer mode: a 48-clock window holds a whole number of prescale periods
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_CNT_LOW, 8'h00);
      wr(ADDR_CNT_HIGH, 8'h00);
      wr(ADDR_CONTROL, 8'h04);
      repeat (47) @(posedge clk_i);
      rd(ADDR_CNT_LOW, 8'h04);
      // Fast speed; let the free prescaler settle into its new period first
      speed <= 1'b1;
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_CNT_LOW, 8'h00);
      repeat (16) @(posedge clk_i);
      wr(ADDR_CONTROL, 8'h04);
      repeat (47) @(posedge clk_i);
      rd(ADDR_CNT_LOW, 8'h0C);
      repeat (3) @(posedge clk_i);
      finish_test();
   end
endmodule
`default_nettype wire
